// [frp_pkg.sv]
// Shared constants and types for the FIFO read-port pair.
// Assumes both ends run on one clock, core_clk at 200 MHz.
package frp_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 40;
    localparam int ADDR_W = 14;
    // Offset spans bits 0..X, X = 14 for the smallest SDR variant
    localparam int OFF_W = 15;
    localparam int PAIR_W = 2 * OFF_W;
    localparam logic [ADDR_W:0] DEPTH_STD = 15'h4000;
    localparam logic [4:0] PAIR_LAST = 5'h1d;
    localparam logic [4:0] IDX_ZERO = 5'h00;
    localparam logic [4:0] IDX_ONE = 5'h01;

    // ------------------------------------------------------------
    // Reset values and host limits
    // ------------------------------------------------------------
    localparam logic [OFF_W-1:0] PAE_DEF = 15'h007f;
    localparam logic [OFF_W-1:0] PAF_DEF = 15'h007f;
    localparam logic [ADDR_W:0] MARK_MIN_WORDS = 15'h0010;
    localparam logic [ADDR_W:0] ONE_WORD = 15'h0001;

    // ------------------------------------------------------------
    // Host sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FRP_IDLE = 4'h1,
        FRP_SELECT = 4'h2,
        FRP_READ = 4'h4,
        FRP_LOAD = 4'h8
    } frp_state_t;

endpackage

// [frp_fifo_if.sv]
// Pins between the FIFO read-port device and its host controller.
// Assumes both ends sit on core_clk; the testbench joins them.
`timescale 1ns/100ps
interface frp_fifo_if;
    import frp_pkg::*;
    logic writeEnableN;
    logic [DATA_W-1:0] dataIn;
    logic inputReadyN;
    logic readSelectN;
    logic readEnableN;
    logic outputEnableN;
    logic retransmitRequestN;
    logic markRequestN;
    logic [DATA_W-1:0] dataOutBus;
    logic dataOutOe;
    logic emptyFlagN;
    logic outputReadyN;
    logic almostFullFlagN;
    logic almostEmptyFlagN;
    logic echoReadEnableN;
    logic serialLoadN;
    logic serialReadEnableN;
    logic serialIn;
    logic serialOut;

    modport dev (
        input writeEnableN, dataIn, readSelectN, readEnableN,
        input outputEnableN, retransmitRequestN, markRequestN,
        input serialLoadN, serialReadEnableN, serialIn,
        output inputReadyN, dataOutBus, dataOutOe, emptyFlagN,
        output outputReadyN, almostFullFlagN, almostEmptyFlagN,
        output echoReadEnableN, serialOut
    );

    modport host (
        output writeEnableN, dataIn, readSelectN, readEnableN,
        output outputEnableN, retransmitRequestN, markRequestN,
        output serialLoadN, serialReadEnableN, serialIn,
        input inputReadyN, dataOutBus, dataOutOe, emptyFlagN,
        input outputReadyN, almostFullFlagN, almostEmptyFlagN,
        input echoReadEnableN, serialOut
    );
endinterface

// [frp_device.sv]
// FIFO device end: storage, read-port sequencing, mark/retransmit,
// serial offset registers, echo read enable and programmable flags.
// Assumes the host drives the pins from logic on core_clk.
//
// Function
// R01 - Host waits one cycle between select and enable
// R02 - Early enable drops first word, shows second
// R03 - First word falls through; later reads need both
// R04 - Select high freezes read pointer
// R05 - Retransmit done shown by empty/ready flag
// R06 - Host keeps retransmit high while reading
// R07 - Write pointer never passes the mark
// R08 - Host marks only with sixteen words stored
// R09 - Double rate marks only even words
// R10 - Offset value spans bits zero to X
// R11 - Read-back always starts at first offset bit
// R12 - Standard echo is select OR enable, high empty
// R13 - Echo enable registered on read clock
// R14 - Fall-through echo low only ready, select, enable
// R15 - Fall-in pulses echo low even unselected
// R16 - Bus driven only with select and output enable
// R17 - Read past last word raises ready and echo
// R18 - Almost-full updated on write clock edges
// R19 - Fall-through depth one word deeper
// R20 - Almost-full release may lag one cycle
// R21 - Almost-empty updated on read clock edges
// R22 - Almost-full low when free at/below offset
// R23 - Host keeps read clock free running
`timescale 1ns/100ps
module frp_device
    import frp_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic fallThroughMode,
    input wire logic ddrMode,
    frp_fifo_if.dev bus
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] wrPtr;
        logic [ADDR_W-1:0] rdPtr;
        logic [ADDR_W-1:0] markPtr;
        logic [ADDR_W:0] count;
        logic markSet;
        logic fall_through_mode;
        logic ddr;
        logic outValid;
        logic srenPrevN;
        logic [OFF_W-1:0] paeOff;
        logic [OFF_W-1:0] pafOff;
        logic [4:0] serIdx;
        logic [DATA_W-1:0] outReg;
        logic [DATA_W-1:0] dataOut;
        logic dataOutOe;
        logic emptyN;
        logic orN;
        logic inReadyN;
        logic pafN;
        logic paeN;
        logic erenN;
        logic serOut;
    } frp_dev_t;

    frp_dev_t s_reg;
    frp_dev_t s_next;
    logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];

    logic rcsN;
    logic renN;
    logic [ADDR_W:0] held;
    logic [ADDR_W:0] heldNew;
    logic [ADDR_W:0] words;
    logic [ADDR_W:0] freeLoc;
    logic [ADDR_W:0] depthEff;
    logic [PAIR_W-1:0] pair;
    logic full;
    logic wrOk;
    logic stdRead;
    logic fwftPop;
    logic fallIn;
    logic loadOut;
    logic rewind;

    assign rcsN = bus.readSelectN;
    assign renN = bus.readEnableN;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Everything below is one synchronous step of the whole block
    always_comb begin
        s_next = s_reg;
        // Words between mark and read pointer are protected
        held = s_reg.markSet ?
            {1'b0, s_reg.rdPtr - s_reg.markPtr} : '0;
        full = (s_reg.count + held) == DEPTH_STD; // R07
        wrOk = !bus.writeEnableN && !full; // R07
        stdRead = !s_reg.fall_through_mode && !rcsN && !renN &&
            (s_reg.count != '0); // R04
        // Popping with select low and enable low; an early enable
        // pops the fallen word before the bus opens
        fwftPop = s_reg.fall_through_mode && !rcsN && !renN && s_reg.outValid; // R02
        fallIn = s_reg.fall_through_mode && !s_reg.outValid &&
            (s_reg.count != '0); // R03
        loadOut = stdRead || fallIn ||
            (fwftPop && (s_reg.count != '0));
        rewind = !bus.retransmitRequestN && s_reg.markSet;

        // Read side: output register load and pointer advance
        if (loadOut) begin
            s_next.outReg = mem[s_reg.rdPtr];
            s_next.rdPtr = s_reg.rdPtr + 1'b1;
        end
        if (fallIn) begin
            s_next.outValid = 1'b1;
        end else if (fwftPop && (s_reg.count == '0)) begin
            s_next.outValid = 1'b0; // R17
        end
        s_next.count = s_reg.count + {{ADDR_W{1'b0}}, wrOk}
            - {{ADDR_W{1'b0}}, loadOut};
        if (wrOk) begin
            s_next.wrPtr = s_reg.wrPtr + 1'b1;
        end

        // Retransmit rewinds reads to the mark, wins over reads
        if (rewind) begin
            s_next.rdPtr = s_reg.markPtr;
            s_next.count = s_reg.count + held +
                {{ADDR_W{1'b0}}, wrOk};
            s_next.outValid = 1'b0;
        end

        // Mark capture; double rate keeps only even words
        if (!bus.markRequestN && !rewind &&
            (!s_reg.ddr || !s_next.rdPtr[0])) begin // R09
            s_next.markPtr = s_next.rdPtr;
            s_next.markSet = 1'b1;
        end

        // Flags from the state being entered
        heldNew = s_next.markSet ?
            {1'b0, s_next.rdPtr - s_next.markPtr} : '0;
        words = s_next.count + {{ADDR_W{1'b0}}, s_next.outValid};
        depthEff = DEPTH_STD + {{ADDR_W{1'b0}}, s_reg.fall_through_mode}; // R19
        freeLoc = depthEff - words - heldNew;
        s_next.inReadyN = (s_next.count + heldNew) == DEPTH_STD;
        // Single clock: both flags settle on the same edge, so
        // almost-full never shows the extra lag it is allowed
        s_next.pafN = !(freeLoc <= {1'b0, s_reg.pafOff}); // R18 R20 R22
        s_next.paeN = !(words <= {1'b0, s_reg.paeOff}); // R21
        s_next.emptyN = s_next.count != '0;
        s_next.orN = !s_next.outValid;
        // Flags drop for the rewind cycle, then recover
        if (rewind) begin
            s_next.emptyN = 1'b0; // R05
            s_next.orN = 1'b1; // R05
        end

        // Echo read enable, registered like every output
        if (s_reg.fall_through_mode) begin
            s_next.erenN = !(fallIn ||
                (fwftPop && (s_reg.count != '0))); // R13 R14 R15 R17
        end else begin
            s_next.erenN = rcsN || renN ||
                (s_reg.count == '0); // R12 R13
        end

        // Bus gating; data follows the output register
        s_next.dataOutOe = !rcsN && !bus.outputEnableN; // R16
        s_next.dataOut = s_next.outReg;

        // Serial offsets, almost-empty low half, first bit first
        pair = {s_reg.pafOff, s_reg.paeOff};
        if (!bus.serialLoadN) begin
            {s_next.pafOff, s_next.paeOff} =
                {bus.serialIn, pair[PAIR_W-1:1]}; // R10
        end
        if (!bus.serialReadEnableN && s_reg.srenPrevN) begin
            s_next.serIdx = IDX_ZERO; // R11
        end else if (!bus.serialReadEnableN) begin
            s_next.serIdx = (s_reg.serIdx == PAIR_LAST) ?
                IDX_ZERO : s_reg.serIdx + IDX_ONE;
        end
        s_next.serOut = pair[s_next.serIdx];
        s_next.srenPrevN = bus.serialReadEnableN;

        // Synchronous reset; mode straps caught here
        if (srst) begin
            s_next = '0;
            s_next.fall_through_mode = fallThroughMode;
            s_next.ddr = ddrMode;
            s_next.paeOff = PAE_DEF;
            s_next.pafOff = PAF_DEF;
            s_next.srenPrevN = 1'b1;
            s_next.orN = 1'b1;
            s_next.pafN = 1'b1;
            s_next.erenN = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers and storage
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        s_reg <= s_next;
    end

    // No reset on the array: contents are don't-care until written
    always_ff @(posedge core_clk) begin
        if (wrOk && !srst) begin
            mem[s_reg.wrPtr] <= bus.dataIn;
        end
    end

    assign bus.inputReadyN = s_reg.inReadyN;
    assign bus.dataOutBus = s_reg.dataOut;
    assign bus.dataOutOe = s_reg.dataOutOe;
    assign bus.emptyFlagN = s_reg.emptyN;
    assign bus.outputReadyN = s_reg.orN;
    assign bus.almostFullFlagN = s_reg.pafN;
    assign bus.almostEmptyFlagN = s_reg.paeN;
    assign bus.echoReadEnableN = s_reg.erenN;
    assign bus.serialOut = s_reg.serOut;

endmodule

// [frp_host.sv]
// Host controller end: drives the FIFO pins from a simple user port.
// Assumes the device runs in fall-through mode on the same core_clk.
`timescale 1ns/100ps
module frp_host
    import frp_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wrValid,
    input wire logic [DATA_W-1:0] wrData,
    output logic wrReady,
    input wire logic rdReq,
    output logic [DATA_W-1:0] rdData,
    output logic rdValid,
    input wire logic markReq,
    input wire logic rewindReq,
    input wire logic loadReq,
    input wire logic [OFF_W-1:0] loadPae,
    input wire logic [OFF_W-1:0] loadPaf,
    output logic busy,
    frp_fifo_if.host bus
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        frp_state_t state;
        logic [ADDR_W:0] level;
        logic weN;
        logic [DATA_W-1:0] wData;
        logic rcsN;
        logic renN;
        logic rtN;
        logic markN;
        logic sloadN;
        logic sin;
        logic [PAIR_W-1:0] sbits;
        logic [4:0] scnt;
        logic [DATA_W-1:0] rData;
        logic rValid;
        logic wReady;
        logic busyF;
    } frp_host_t;

    frp_host_t h_reg;
    frp_host_t h_next;
    logic wrTaken;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        h_next = h_reg;
        h_next.rValid = 1'b0;
        h_next.markN = 1'b1;
        // Retransmit is only ever a lone idle pulse
        h_next.rtN = 1'b1; // R06
        wrTaken = !h_reg.weN && !bus.inputReadyN;
        // Almost-full as ready leaves the offset as slack
        h_next.wReady = bus.almostFullFlagN;
        h_next.weN = !(wrValid && h_reg.wReady);
        h_next.wData = wrData;
        if (wrTaken) begin
            h_next.level = h_reg.level + ONE_WORD;
        end
        case (h_reg.state)
            FRP_IDLE: begin
                if (loadReq) begin
                    h_next.sbits = {loadPaf, loadPae}; // R10
                    h_next.sin = loadPae[0];
                    h_next.sloadN = 1'b0;
                    h_next.scnt = IDX_ZERO;
                    h_next.state = FRP_LOAD;
                end else if (rdReq && !bus.outputReadyN) begin
                    // Select first, enable stays high one cycle
                    h_next.rcsN = 1'b0; // R01
                    h_next.renN = 1'b1; // R01
                    h_next.state = FRP_SELECT;
                end else if (markReq &&
                    (h_reg.level >= MARK_MIN_WORDS)) begin // R08
                    h_next.markN = 1'b0;
                end else if (rewindReq) begin
                    h_next.rtN = 1'b0;
                    // Occupancy unknown after a rewind: stay safe
                    h_next.level = '0;
                end
            end
            FRP_SELECT: begin
                h_next.renN = 1'b0;
                h_next.state = FRP_READ;
            end
            FRP_READ: begin
                h_next.rData = bus.dataOutBus;
                h_next.rValid = bus.dataOutOe;
                h_next.rcsN = 1'b1;
                h_next.renN = 1'b1;
                if (h_next.level != '0) begin
                    h_next.level = h_next.level - ONE_WORD;
                end
                h_next.state = FRP_IDLE;
            end
            FRP_LOAD: begin
                h_next.sbits = {1'b0, h_reg.sbits[PAIR_W-1:1]};
                h_next.sin = h_reg.sbits[1];
                h_next.scnt = h_reg.scnt + IDX_ONE;
                if (h_reg.scnt == PAIR_LAST) begin
                    h_next.sloadN = 1'b1;
                    h_next.state = FRP_IDLE;
                end
            end
            default: begin
                h_next.state = FRP_IDLE;
            end
        endcase
        h_next.busyF = h_next.state != FRP_IDLE;
        if (srst) begin
            h_next = '0;
            h_next.state = FRP_IDLE;
            h_next.weN = 1'b1;
            h_next.rcsN = 1'b1;
            h_next.renN = 1'b1;
            h_next.rtN = 1'b1;
            h_next.markN = 1'b1;
            h_next.sloadN = 1'b1;
        end
    end

    // Clock is never gated here, so flags keep updating
    always_ff @(posedge core_clk) begin
        h_reg <= h_next; // R23
    end

    assign bus.writeEnableN = h_reg.weN;
    assign bus.dataIn = h_reg.wData;
    assign bus.readSelectN = h_reg.rcsN;
    assign bus.readEnableN = h_reg.renN;
    assign bus.outputEnableN = 1'b0;
    assign bus.retransmitRequestN = h_reg.rtN;
    assign bus.markRequestN = h_reg.markN;
    assign bus.serialLoadN = h_reg.sloadN;
    assign bus.serialReadEnableN = 1'b1;
    assign bus.serialIn = h_reg.sin;
    assign wrReady = h_reg.wReady;
    assign rdData = h_reg.rData;
    assign rdValid = h_reg.rValid;
    assign busy = h_reg.busyF;

endmodule

// [frp_read_port_asserts.sv]
// Concurrent checks on the pins between the FIFO device and its host.
// Assumes fall-through mode, single data rate and one clock, core_clk.
`timescale 1ns/100ps
module frp_read_port_asserts (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic readSelectN,
    input wire logic readEnableN,
    input wire logic outputEnableN,
    input wire logic retransmitRequestN,
    input wire logic markRequestN,
    input wire logic dataOutOe,
    input wire logic outputReadyN,
    input wire logic echoReadEnableN
);
    // ------------------------------------------------------------
    // Read port sequencing
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_bus_drive;
        !$past(srst) |-> dataOutOe == $past(!readSelectN && !outputEnableN);
    endproperty
    a_bus_drive: assert property (p_bus_drive)
        else $error("bus driven without select and output enable");

    // Echo low only for a pop or a fresh fall-in
    property p_echo_cause;
        !echoReadEnableN |-> $fell(outputReadyN) ||
            $past(!readSelectN && !readEnableN && !outputReadyN);
    endproperty
    a_echo_cause: assert property (p_echo_cause)
        else $error("echo low without a new word");

    property p_empty_read;
        $rose(outputReadyN) |-> echoReadEnableN;
    endproperty
    a_empty_read: assert property (p_empty_read)
        else $error("echo low while output register ran dry");

    property p_select_freeze;
        readSelectN && !outputReadyN && retransmitRequestN
            |=> !outputReadyN && echoReadEnableN;
    endproperty
    a_select_freeze: assert property (p_select_freeze)
        else $error("word consumed while unselected");

    // Rewind empties the register, then marked words fall in again
    property p_rewind_done;
        $fell(retransmitRequestN) |=> outputReadyN ##[1:3] !outputReadyN;
    endproperty
    a_rewind_done: assert property (p_rewind_done)
        else $error("rewind did not refill the output register");

    property p_rewind_quiet;
        !readEnableN |-> retransmitRequestN;
    endproperty
    a_rewind_quiet: assert property (p_rewind_quiet)
        else $error("rewind requested during a read");

    property p_enable_gap;
        $fell(readSelectN) |-> readEnableN;
    endproperty
    a_enable_gap: assert property (p_enable_gap)
        else $error("enable low with select");

    property p_mark_pulse;
        !markRequestN |=> markRequestN;
    endproperty
    a_mark_pulse: assert property (p_mark_pulse)
        else $error("mark request longer than one cycle");
endmodule

// [testbench.sv]
// Self-checking bench: host and device joined through the interface.
// Assumes fall-through straps and a 200 MHz core_clk.
`timescale 1ns/100ps
module testbench;
    import frp_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and bookkeeping
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic wrValid = 1'b0, rdReq = 1'b0, markReq = 1'b0;
    logic rewindReq = 1'b0, loadReq = 1'b0;
    logic [DATA_W-1:0] wrData = '0;
    logic [OFF_W-1:0] loadPae = '0, loadPaf = '0, paeOff, pafOff;
    logic wrReady, rdValid, busy;
    logic [DATA_W-1:0] rdData, d;
    logic [DATA_W-1:0] exp[$];
    logic [31:0] rnd = 32'h62c4;
    int badCount = 0, compares = 0, wrTot = 0, rdCnt = 0, k, markRd = -1;

    frp_fifo_if bus();
    frp_device u_frp_device (.core_clk(core_clk), .srst(srst),
        .fallThroughMode(1'b1), .ddrMode(1'b0), .bus(bus));
    frp_host u_frp_host (.core_clk(core_clk), .srst(srst),
        .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
        .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid),
        .markReq(markReq), .rewindReq(rewindReq), .loadReq(loadReq),
        .loadPae(loadPae), .loadPaf(loadPaf), .busy(busy), .bus(bus));
    frp_read_port_asserts u_frp_read_port_asserts (.core_clk(core_clk),
        .srst(srst), .readSelectN(bus.readSelectN),
        .readEnableN(bus.readEnableN), .outputEnableN(bus.outputEnableN),
        .retransmitRequestN(bus.retransmitRequestN),
        .markRequestN(bus.markRequestN), .dataOutOe(bus.dataOutOe),
        .outputReadyN(bus.outputReadyN),
        .echoReadEnableN(bus.echoReadEnableN));

    always #2.5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected flag levels; fall-through depth counts the output register
    function automatic logic aeExp(input int lvl, input int off);
        return lvl > off;
    endfunction
    function automatic logic afExp(input int lvl, input int off);
        return (int'(DEPTH_STD) + 1 - lvl) > off;
    endfunction

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] want);
        compares++;
        if (seen !== want) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask

    // A wait that runs out ends the run as a mismatch
    task automatic timed_out();
        check('0, '1);
        close_out();
    endtask

    task automatic wait_idle();
        k = 0;
        @(negedge core_clk);
        while (busy !== 1'b0) begin
            k++;
            if (k > 60) timed_out();
            @(negedge core_clk);
        end
    endtask

    // Holds wrValid across the burst; a stall ends a may-stall burst
    task automatic write_burst(input int n, input bit mayStall);
        int sent, idle;
        sent = 0;
        idle = 0;
        rnd = step(rnd);
        @(posedge core_clk);
        wrValid <= 1'b1;
        wrData <= {rnd[7:0], rnd};
        while (sent < n) begin
            @(negedge core_clk);
            if (wrReady === 1'b1) begin
                @(posedge core_clk);
                exp.push_back(wrData);
                sent++;
                wrTot++;
                idle = 0;
                rnd = step(rnd);
                if (sent < n) wrData <= {rnd[15:8], rnd};
                else wrValid <= 1'b0;
            end else begin
                idle++;
                if (idle > 40) begin
                    if (!mayStall) timed_out();
                    @(posedge core_clk);
                    wrValid <= 1'b0;
                    sent = n;
                end
            end
        end
    endtask

    task automatic read_one(output logic [DATA_W-1:0] v);
        k = 0;
        @(negedge core_clk);
        while (!(bus.outputReadyN === 1'b0 && busy === 1'b0)) begin
            k++;
            if (k > 60) timed_out();
            @(negedge core_clk);
        end
        @(posedge core_clk) rdReq <= 1'b1;
        @(posedge core_clk) rdReq <= 1'b0;
        k = 0;
        @(negedge core_clk);
        while (rdValid !== 1'b1) begin
            k++;
            if (k > 10) timed_out();
            @(negedge core_clk);
        end
        v = rdData;
        rdCnt++;
    endtask

    // Serial load goes out LSB first, almost-empty half first
    task automatic load_offsets(input logic [OFF_W-1:0] ae,
                                input logic [OFF_W-1:0] af);
        logic [PAIR_W-1:0] pair;
        pair = {af, ae};
        @(posedge core_clk);
        loadReq <= 1'b1;
        loadPae <= ae;
        loadPaf <= af;
        @(posedge core_clk) loadReq <= 1'b0;
        for (int i = 0; i < PAIR_W; i++) begin
            @(negedge core_clk);
            check(DATA_W'({bus.serialLoadN, bus.serialIn}),
                  DATA_W'({1'b0, pair[i]}));
        end
        wait_idle();
        paeOff = ae;
        pafOff = af;
    endtask

    task automatic pulse(input bit rewind);
        @(posedge core_clk);
        if (rewind) rewindReq <= 1'b1;
        else markReq <= 1'b1;
        @(posedge core_clk);
        rewindReq <= 1'b0;
        markReq <= 1'b0;
        wait_idle();
    endtask

    task automatic check_flags();
        int lvl, occ;
        lvl = wrTot - rdCnt;
        // Once marked, words read since the mark still take space
        occ = (markRd < 0) ? lvl : wrTot - markRd;
        repeat (4) @(negedge core_clk);
        check(DATA_W'(bus.almostEmptyFlagN),
              DATA_W'(aeExp(lvl, int'(paeOff))));
        check(DATA_W'(bus.almostFullFlagN),
              DATA_W'(afExp(occ, int'(pafOff))));
        // Fall-through keeps one word out of the RAM count
        check(DATA_W'(bus.emptyFlagN), DATA_W'(lvl > 1));
        check(DATA_W'(bus.inputReadyN),
              DATA_W'(occ > int'(DEPTH_STD)));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        check(DATA_W'({bus.echoReadEnableN, bus.outputReadyN,
              bus.dataOutOe}), DATA_W'(3'h6));
        rnd = step(rnd);
        load_offsets(15'h0002 + 15'(rnd[2:0]), 15'h0003 + 15'(rnd[6:3]));
        // Lone word falls in with nobody selecting it
        write_burst(1, 1'b0);
        k = 0;
        @(negedge core_clk);
        while (bus.outputReadyN !== 1'b0) begin
            k++;
            if (k > 20) timed_out();
            @(negedge core_clk);
        end
        check(DATA_W'({bus.echoReadEnableN, bus.readSelectN}),
              DATA_W'(2'h1));
        @(negedge core_clk);
        check(DATA_W'(bus.echoReadEnableN), DATA_W'(1'b1));
        read_one(d);
        check(d, exp[0]);
        check_flags();
        // Back-to-back burst, then mark and rewind mid-stream
        write_burst(20, 1'b0);
        check_flags();
        for (int i = 1; i < 3; i++) begin
            read_one(d);
            check(d, exp[i]);
        end
        pulse(1'b0);
        // Mark takes the RAM read pointer, one past the fallen word
        markRd = rdCnt;
        for (int i = 3; i < 6; i++) begin
            read_one(d);
            check(d, exp[i]);
        end
        pulse(1'b1);
        read_one(d);
        check(d, exp[markRd + 1]);
        read_one(d);
        check(d, exp[markRd + 2]);
        // Second reset mid-run, then fill towards almost full
        @(posedge core_clk) srst <= 1'b1;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        exp.delete();
        wrTot = 0;
        rdCnt = 0;
        markRd = -1;
        paeOff = PAE_DEF;
        pafOff = PAF_DEF;
        check_flags();
        write_burst(16400, 1'b1);
        check_flags();
        check(DATA_W'(bus.almostFullFlagN), '0);
        // Single reads walk almost-full across its edge at 127 free words of D = 16385
        repeat (6) begin
            read_one(d);
            check(d, exp[rdCnt - 1]);
            check_flags();
        end
        // With a mark set, reading must not free any space
        pulse(1'b0);
        markRd = rdCnt;
        write_burst(40, 1'b1);
        repeat (6) begin
            read_one(d);
            check(d, exp[rdCnt - 1]);
            check_flags();
        end
        close_out();
    end
endmodule
